/* async_memory_strobe_sequencer.sv */
// strobe sequencer for asynchronous memory cycles
`timescale 1ns/1ps
module async_memory_strobe_sequencer (
   // clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 rst,
   // per-space timing settings
   input  wire strobe_seq_pkg::space_timing_t        space_timing
                                                     [strobe_seq_pkg::SPACES],
   // request from the core
   input  wire logic                                 req_valid,
   output wire logic                                 req_ready,
   input  wire logic                                 req_write,
   input  wire logic [strobe_seq_pkg::SPACE_W-1:0]   req_space,
   input  wire logic [strobe_seq_pkg::ADDR_W-1:0]    req_addr,
   input  wire logic [strobe_seq_pkg::LANE_W-1:0]    req_lanes,
   input  wire logic [strobe_seq_pkg::DATA_W-1:0]    req_wdata,
   output logic                                      rsp_valid,
   output logic      [strobe_seq_pkg::DATA_W-1:0]    rsp_rdata,
   // external memory port
   output logic      [strobe_seq_pkg::SPACES-1:0]    space_select_n,
   output logic      [strobe_seq_pkg::LANE_W-1:0]    byte_lane_n,
   output logic      [strobe_seq_pkg::ADDR_W-1:0]    word_address,
   output logic                                      output_enable_n,
   output logic                                      read_strobe_n,
   output logic                                      write_strobe_n,
   input  wire logic [strobe_seq_pkg::DATA_W-1:0]    memory_data_bus_in,
   output logic      [strobe_seq_pkg::DATA_W-1:0]    memory_data_bus_out,
   output logic                                      memory_data_bus_oe,
   input  wire logic                                 memory_ready_in
);
   import strobe_seq_pkg::*;

   // ***************************************************
   // ready synchronizer
   // ***************************************************
   ready_sync_if rsi ();
   assign rsi.ready_raw = memory_ready_in;

   ready_sync u_ready_sync (
      .clk (clk),
      .rst (rst),
      .rs  (rsi.sync_side)
   );

   // ***************************************************
   // sequencer state
   // ***************************************************
   seq_state_t          state_ff,   nxt_state;
   logic [CNT_W-1:0]    cnt_ff,     nxt_cnt;
   logic                write_ff,   nxt_write;
   logic [SPACE_W-1:0]  space_ff,   nxt_space;
   logic [ADDR_W-1:0]   addr_ff,    nxt_addr;
   logic [LANE_W-1:0]   lanes_ff,   nxt_lanes;
   logic [DATA_W-1:0]   wdata_ff,   nxt_wdata;
   logic [DATA_W-1:0]   rdata_ff,   nxt_rdata;
   logic                rsp_ff,     nxt_rsp;
   logic                stretch_ff, nxt_stretch;
   space_timing_t       tm;
   logic [CNT_W-1:0]    setup_c;
   logic [CNT_W-1:0]    strobe_c;
   logic [CNT_W-1:0]    hold_c;
   logic [CNT_W-1:0]    tail_c;
   logic [CNT_W:0]      sum_c;
   logic                ext_ok;

   assign tm       = space_timing[space_ff];
   assign setup_c  = write_ff ? tm.wr_setup  : tm.rd_setup;
   assign strobe_c = write_ff ? tm.wr_strobe : tm.rd_strobe;
   assign hold_c   = write_ff ? tm.wr_hold   : tm.rd_hold;
   assign sum_c    = {1'b0, setup_c} + {1'b0, strobe_c};
   assign ext_ok   = sum_c >= (CNT_W+1)'(READY_MIN_SUM);

   // chip select tail after the hold phase
   always_comb begin
      if (!write_ff) begin
         tail_c = (hold_c >= CNT_W'(CS_TAIL_READ)) ? '0
                : CNT_W'(CS_TAIL_READ) - hold_c;
      end else if (hold_c == '0) begin
         tail_c = CNT_W'(CS_TAIL_WR_NOH);
      end else begin
         tail_c = CNT_W'(CS_TAIL_WR_HLD);
      end
   end

   assign req_ready = (state_ff == ST_IDLE) || (state_ff == ST_TAIL);

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_write   = write_ff;
      nxt_space   = space_ff;
      nxt_addr    = addr_ff;
      nxt_lanes   = lanes_ff;
      nxt_wdata   = wdata_ff;
      nxt_rdata   = rdata_ff;
      nxt_rsp     = 1'b0;
      nxt_stretch = stretch_ff;
      unique case (state_ff)
         ST_IDLE, ST_TAIL: begin
            if (state_ff == ST_TAIL) begin
               if (cnt_ff <= CNT_ONE) begin
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_cnt = cnt_ff - CNT_ONE;
               end
            end
            if (req_valid) begin
               nxt_state   = ST_SETUP;
               nxt_write   = req_write;
               nxt_space   = req_space;
               nxt_addr    = req_addr;
               nxt_lanes   = req_lanes;
               nxt_wdata   = req_wdata;
               nxt_cnt     = req_write ? space_timing[req_space].wr_setup
                                       : space_timing[req_space].rd_setup;
               nxt_stretch = 1'b0;
            end
         end
         ST_SETUP: begin
            if (cnt_ff <= CNT_ONE) begin
               nxt_state = ST_STROBE;
               nxt_cnt   = (strobe_c == '0) ? CNT_ONE : strobe_c;
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         ST_STROBE: begin
            // sample ready a fixed distance before the nominal end
            if (ext_ok && !stretch_ff
                && cnt_ff == CNT_W'(READY_SAMPLE) && !rsi.ready_sync) begin
               nxt_stretch = 1'b1;
            end else if (stretch_ff) begin
               if (rsi.ready_sync) begin
                  // end one cycle later: strobe rises 3 to 4 cycles after ready
                  nxt_stretch = 1'b0;
                  nxt_cnt     = CNT_ONE;
               end
            end else if (cnt_ff <= CNT_ONE) begin
               nxt_state = ST_HOLD;
               nxt_cnt   = hold_c;
               if (!write_ff) begin
                  nxt_rdata = memory_data_bus_in;
                  nxt_rsp   = 1'b1;
               end
               if (hold_c == '0) begin
                  nxt_state = ST_TAIL;
                  nxt_cnt   = tail_c;
                  nxt_rsp   = 1'b1;
               end
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         ST_HOLD: begin
            if (cnt_ff <= CNT_ONE) begin
               if (write_ff) begin
                  nxt_rsp = 1'b1;
               end
               nxt_state = (tail_c == '0) ? ST_IDLE : ST_TAIL;
               nxt_cnt   = tail_c;
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff   <= ST_IDLE;
         cnt_ff     <= '0;
         write_ff   <= 1'b0;
         space_ff   <= '0;
         addr_ff    <= '0;
         lanes_ff   <= '0;
         wdata_ff   <= '0;
         rdata_ff   <= '0;
         rsp_ff     <= 1'b0;
         stretch_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         write_ff   <= nxt_write;
         space_ff   <= nxt_space;
         addr_ff    <= nxt_addr;
         lanes_ff   <= nxt_lanes;
         wdata_ff   <= nxt_wdata;
         rdata_ff   <= nxt_rdata;
         rsp_ff     <= nxt_rsp;
         stretch_ff <= nxt_stretch;
      end
   end

   // ***************************************************
   // pin drivers
   // ***************************************************
   logic [SPACES-1:0] sel_n_ff,  nxt_sel_n;
   logic [LANE_W-1:0] lane_n_ff, nxt_lane_n;
   logic              oe_n_ff,   nxt_oe_n;
   logic              rd_n_ff,   nxt_rd_n;
   logic              wr_n_ff,   nxt_wr_n;
   logic              doe_ff,    nxt_doe;
   logic              busy_nxt;

   always_comb begin
      busy_nxt   = (nxt_state == ST_SETUP) || (nxt_state == ST_STROBE)
                || (nxt_state == ST_HOLD);
      nxt_sel_n  = '1;
      if (busy_nxt || nxt_state == ST_TAIL) begin
         nxt_sel_n[nxt_space] = 1'b0;
      end
      nxt_lane_n = busy_nxt ? ~nxt_lanes : '1;
      nxt_oe_n   = !(busy_nxt && !nxt_write);
      nxt_rd_n   = !(nxt_state == ST_STROBE && !nxt_write);
      nxt_wr_n   = !(nxt_state == ST_STROBE && nxt_write);
      nxt_doe    = busy_nxt && nxt_write;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_n_ff  <= '1;
         lane_n_ff <= '1;
         oe_n_ff   <= 1'b1;
         rd_n_ff   <= 1'b1;
         wr_n_ff   <= 1'b1;
         doe_ff    <= 1'b0;
      end else begin
         sel_n_ff  <= nxt_sel_n;
         lane_n_ff <= nxt_lane_n;
         oe_n_ff   <= nxt_oe_n;
         rd_n_ff   <= nxt_rd_n;
         wr_n_ff   <= nxt_wr_n;
         doe_ff    <= nxt_doe;
      end
   end

   assign space_select_n      = sel_n_ff;
   assign byte_lane_n         = lane_n_ff;
   assign word_address        = addr_ff;
   assign output_enable_n     = oe_n_ff;
   assign read_strobe_n       = rd_n_ff;
   assign write_strobe_n      = wr_n_ff;
   assign memory_data_bus_out = wdata_ff;
   assign memory_data_bus_oe  = doe_ff;
   assign rsp_valid           = rsp_ff;
   assign rsp_rdata           = rdata_ff;
endmodule // async_memory_strobe_sequencer

/* strobe_seq_pkg.sv */
// constants and types for the asynchronous memory strobe sequencer
//
// Function
// - selects and output enable valid for read setup cycles first.
// - read strobe low for read strobe cycles unless ready stretches.
// - selects stay stable for read hold cycles after read strobe.
// - selects and write data valid for write setup cycles first.
// - write strobe low for write strobe cycles unless ready stretches.
// - selects and write data stay for write hold cycles after strobe.
// - ready input passes a synchronizer and may act a cycle late.
// - stretched strobe ends three to four cycles after ready rises.
// - ready stretching needs setup plus strobe of at least four.
// - chip select may stay active up to seven cycles after a cycle.
// - counts come from per-space timing settings.
// - after a read, chip select stays active seven minus read hold.
// - after a write, chip select stays three cycles, four if hold zero.
package strobe_seq_pkg;
   localparam int CNT_W          = 6;
   localparam int SPACES         = 4;
   localparam int SPACE_W        = 2;
   localparam int ADDR_W         = 20;
   localparam int DATA_W         = 32;
   localparam int LANE_W         = 4;
   localparam int CS_TAIL_READ   = 7;
   localparam int CS_TAIL_WR_HLD = 3;
   localparam int CS_TAIL_WR_NOH = 4;
   localparam int READY_MIN_SUM  = 4;
   localparam int READY_SAMPLE   = 3;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

   typedef struct packed {
      logic [CNT_W-1:0] rd_setup;
      logic [CNT_W-1:0] rd_strobe;
      logic [CNT_W-1:0] rd_hold;
      logic [CNT_W-1:0] wr_setup;
      logic [CNT_W-1:0] wr_strobe;
      logic [CNT_W-1:0] wr_hold;
   } space_timing_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_TAIL
   } seq_state_t;
endpackage

/* ready_sync_if.sv */
// carrier between the sequencer and its ready synchronizer
`timescale 1ns/1ps
interface ready_sync_if;
   logic ready_raw;
   logic ready_sync;
   modport sync_side (input ready_raw, output ready_sync);
   modport user_side (output ready_raw, input ready_sync);
endinterface

/* ready_sync.sv */
// two flip-flop synchronizer for the memory ready input
`timescale 1ns/1ps
module ready_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // carrier
   ready_sync_if.sync_side rs
);
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;

   always_comb begin
      nxt_meta = rs.ready_raw;
      nxt_sync = meta_ff;
   end

   // idle high so a missing memory never stalls
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign rs.ready_sync = sync_ff;
endmodule // ready_sync

/* async_memory_strobe_sequencer_monitor.sv */
// assertion checker for the asynchronous memory strobe sequencer
`timescale 1ns/1ps
module async_memory_strobe_sequencer_monitor (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // memory port
   input wire logic [3:0]  space_select_n,
   input wire logic [3:0]  byte_lane_n,
   input wire logic        output_enable_n,
   input wire logic        read_strobe_n,
   input wire logic        write_strobe_n,
   input wire logic [31:0] memory_data_bus_out,
   input wire logic        memory_data_bus_oe,
   input wire logic        memory_ready_in,
   input wire logic        rsp_valid
);
   logic       strobes_n;
   logic       tail_now;
   logic [3:0] tail_ff;
   logic [3:0] nxt_tail;
   assign strobes_n = read_strobe_n & write_strobe_n;
   // chip select low with output enable, write strobe, data drive and byte lanes released
   assign tail_now = !(&space_select_n) && output_enable_n && write_strobe_n
                     && !memory_data_bus_oe && (&byte_lane_n);
   always_comb nxt_tail = tail_now ? tail_ff + 4'h1 : 4'h0;
   always_ff @(posedge clk) tail_ff <= rst ? 4'h0 : nxt_tail;
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_setup_rd;
      $fell(read_strobe_n) |-> !output_enable_n && $past(!output_enable_n)
         && $stable(byte_lane_n);
   endproperty
   property p_setup_wr;
      $fell(write_strobe_n) |-> memory_data_bus_oe
         && $past(memory_data_bus_oe) && $stable(memory_data_bus_out);
   endproperty
   property p_rd_strobe;
      !read_strobe_n |-> !output_enable_n && write_strobe_n
         && !(&space_select_n);
   endproperty
   property p_wr_strobe;
      !write_strobe_n |-> memory_data_bus_oe && output_enable_n
         && !(&space_select_n);
   endproperty
   property p_rd_hold;
      $rose(read_strobe_n) && !(&byte_lane_n) |-> !output_enable_n
         && $stable(byte_lane_n);
   endproperty
   property p_wr_hold;
      $rose(write_strobe_n) && !(&byte_lane_n) |-> memory_data_bus_oe
         && $stable(memory_data_bus_out);
   endproperty
   property p_ready_end;
      $rose(memory_ready_in) && !strobes_n && $past(!strobes_n, 4)
         |=> (!strobes_n)[*3] ##[1:2] strobes_n;
   endproperty
   property p_stretch;
      (!memory_ready_in)[*4] ##0 !strobes_n |=> !strobes_n;
   endproperty
   property p_cs_tail;
      tail_ff <= 4'h7;
   endproperty
   a_setup_rd: assert property (p_setup_rd)
      else $error("read setup short");
   a_setup_wr: assert property (p_setup_wr)
      else $error("write setup short");
   a_rd_strobe: assert property (p_rd_strobe)
      else $error("read selects");
   a_wr_strobe: assert property (p_wr_strobe)
      else $error("write selects");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read hold");
   a_wr_hold: assert property (p_wr_hold)
      else $error("write hold");
   a_ready_end: assert property (p_ready_end)
      else $error("ready end");
   a_stretch: assert property (p_stretch)
      else $error("no stretch");
   a_cs_tail: assert property (p_cs_tail)
      else $error("select tail");
   c_stretch: cover property ($rose(memory_ready_in) && !strobes_n);
   c_rsp: cover property (rsp_valid);
   c_tail: cover property (tail_ff == 4'h7);
endmodule // async_memory_strobe_sequencer_monitor

bind async_memory_strobe_sequencer async_memory_strobe_sequencer_monitor mon (
   .clk(clk), .rst(rst), .space_select_n(space_select_n),
   .byte_lane_n(byte_lane_n), .output_enable_n(output_enable_n),
   .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
   .memory_data_bus_out(memory_data_bus_out),
   .memory_data_bus_oe(memory_data_bus_oe),
   .memory_ready_in(memory_ready_in), .rsp_valid(rsp_valid));

/* async_mem_model.sv */
// behavioural asynchronous memory with a ready output
`timescale 1ns/1ps
module async_mem_model (
   // clock and stall length
   input wire logic        clk,
   input int               stall,
   // memory port
   input wire logic [3:0]  space_select_n,
   input wire logic [3:0]  byte_lane_n,
   input wire logic [19:0] word_address,
   input wire logic        output_enable_n,
   input wire logic        write_strobe_n,
   input wire logic [31:0] wr_data,
   input wire logic        wr_data_oe,
   output logic [31:0]     rd_data,
   output logic            memory_ready = 1'b1
);
   logic [31:0] mem [256] = '{default: 32'h0};
   logic [31:0] word;
   logic        sel_idle;
   assign word = mem[word_address[7:0]];
   assign sel_idle = &space_select_n;
   // undriven bus shows the inverse so stale captures are caught
   assign rd_data = (!sel_idle && !output_enable_n) ? word : ~word;
   always @(posedge clk) begin
      if (!write_strobe_n && !sel_idle && wr_data_oe)
         for (int b = 0; b < 4; b++)
            if (!byte_lane_n[b])
               mem[word_address[7:0]][8*b+:8] <= wr_data[8*b+:8];
   end
   // ready drops at select so the synchronizer sees it before sampling
   always @(negedge sel_idle) begin
      if (stall != 0) begin
         memory_ready = 1'b0;
         repeat (stall) @(posedge clk);
         #3 memory_ready = 1'b1;
      end
   end
endmodule // async_mem_model

/* tb.sv */
// self-checking testbench for the asynchronous memory strobe sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %0h exp %0h", $time, g, e); end end
module tb;
   import strobe_seq_pkg::*;
   typedef struct {
      logic wr; logic [1:0] sp; logic [19:0] ad; logic [3:0] ln;
      logic [31:0] d; logic [31:0] x; int st;
   } op_t;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   space_timing_t tm [SPACES];
   logic          req_valid = 1'b0;
   logic          req_write = 1'b0;
   logic [1:0]    req_space = 2'h0;
   logic [19:0]   req_addr = 20'h0;
   logic [3:0]    req_lanes = 4'h0;
   logic [31:0]   req_wdata = 32'h0;
   logic          req_ready, rsp_valid, oe_n, rd_n, wr_n, d_oe, ready;
   logic [31:0]   rsp_rdata, mem_in, mem_out;
   logic [3:0]    sel_n, lane_n;
   logic [19:0]   addr;
   int            stall = 0;
   int            n_errors = 0;
   int            checked = 0;
   op_t           ops [8];
   async_memory_strobe_sequencer dut (.clk(clk), .rst(rst),
      .space_timing(tm), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_space(req_space), .req_addr(req_addr),
      .req_lanes(req_lanes), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .space_select_n(sel_n), .byte_lane_n(lane_n),
      .word_address(addr), .output_enable_n(oe_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .memory_data_bus_in(mem_in),
      .memory_data_bus_out(mem_out), .memory_data_bus_oe(d_oe),
      .memory_ready_in(ready));
   async_mem_model mem (.clk(clk), .stall(stall), .space_select_n(sel_n),
      .byte_lane_n(lane_n), .word_address(addr), .output_enable_n(oe_n),
      .write_strobe_n(wr_n), .wr_data(mem_out), .wr_data_oe(d_oe),
      .rd_data(mem_in), .memory_ready(ready));
   always #20 clk = ~clk;
   task stop_test;
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one access, counting setup, strobe, hold and tail cycles
   task automatic access(input op_t o);
      int n [4];
      int ph, nr, rs, st, hd, lo;
      logic sn;
      rs = o.wr ? int'(tm[o.sp].wr_setup) : int'(tm[o.sp].rd_setup);
      st = o.wr ? int'(tm[o.sp].wr_strobe) : int'(tm[o.sp].rd_strobe);
      hd = o.wr ? int'(tm[o.sp].wr_hold) : int'(tm[o.sp].rd_hold);
      rs = (rs == 0) ? 1 : rs;
      st = (st == 0) ? 1 : st;
      n = '{0, 0, 0, 0};
      ph = 0;
      nr = 0;
      stall = o.st;
      {req_write, req_space, req_addr, req_lanes, req_wdata} =
         {o.wr, o.sp, o.ad, o.ln, o.d};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      for (int k = 0; k < 200 && !(ph == 3 && &sel_n); k++) begin
         sn = o.wr ? wr_n : rd_n;
         if (!sn) ph = 1;
         else if (ph == 1) ph = 2;
         if (ph == 2 && &lane_n) ph = 3;
         if (!(&sel_n)) n[ph]++;
         if (rsp_valid) nr++;
         if (rsp_valid && !o.wr) `CHK(rsp_rdata, o.x)
         if (!sn) begin
            `CHK(sel_n, ~(4'h1 << o.sp))
            `CHK(lane_n, ~o.ln)
            `CHK(addr, o.ad)
            `CHK(d_oe, o.wr)
            `CHK(o.wr ? mem_out : {31'h0, oe_n}, o.wr ? o.d : 32'h0)
         end
         @(negedge clk);
      end
      lo = o.st + 3 - rs;
      `CHK(nr, 1)
      `CHK(n[0], rs)
      if (o.st == 0) `CHK(n[1], st)
      else `CHK(n[1] >= lo && n[1] <= lo + 1, 1'b1)
      `CHK(n[2], hd)
      `CHK(n[3], o.wr ? (hd == 0 ? 4 : 3) : 7 - hd)
   endtask
   initial begin
      #40000;
      n_errors++;
      stop_test();
   end
   initial begin
      tm[0] = '{6'h02, 6'h03, 6'h01, 6'h02, 6'h03, 6'h01};
      tm[1] = '{6'h01, 6'h04, 6'h00, 6'h03, 6'h02, 6'h00};
      tm[2] = '{6'h03, 6'h05, 6'h02, 6'h01, 6'h04, 6'h02};
      tm[3] = '{6'h00, 6'h00, 6'h03, 6'h00, 6'h01, 6'h01};
      ops[0] = '{1'b1, 2'h0, 20'h10, 4'hf, 32'h11223344, 32'h0, 0};
      ops[1] = '{1'b0, 2'h0, 20'h10, 4'hf, 32'h0, 32'h11223344, 0};
      ops[2] = '{1'b1, 2'h1, 20'h20, 4'h5, 32'haabbccdd, 32'h0, 0};
      ops[3] = '{1'b0, 2'h1, 20'h20, 4'hf, 32'h0, 32'h00bb00dd, 0};
      ops[4] = '{1'b1, 2'h2, 20'h30, 4'hf, 32'h01020304, 32'h0, 8};
      ops[5] = '{1'b0, 2'h2, 20'h30, 4'hf, 32'h0, 32'h01020304, 8};
      ops[6] = '{1'b0, 2'h3, 20'h10, 4'hf, 32'h0, 32'h11223344, 0};
      ops[7] = '{1'b1, 2'h3, 20'h40, 4'h3, 32'h55667788, 32'h0, 0};
      repeat (5) @(negedge clk);
      rst = 1'b0;
      `CHK({sel_n, rd_n, wr_n, oe_n, d_oe, req_ready}, 9'h1fd)
      for (int i = 0; i < 8; i++) access(ops[i]);
      stop_test();
   end
endmodule // tb
